// ==== design/dual_ringer_tone_pwm.sv ====
// Two-channel ringer tone generator with PWM outputs and byte registers
//
// Contract
// - Two independent channels, outputs mixed together
// - Five-bit volume field gives 32 levels
// - Tone is 12.288 MHz over 16, 32, N+1
// - Clock-gate bit 7 runs or stops generator
// - Channel enable writable only while clock runs
// - Zero volume mutes an enabled channel
// - Control bit 7 enables channel; 6:5 reserved
// - Channel one: 768 kHz over 32(N+1)
// - Channel two uses same 768 kHz form
`include "ringer_defs.svh"

module dual_ringer_tone_pwm (
  input  wire logic                      core_clk_i,
  input  wire logic                      arst_n_i,
  input  wire ringer_pkg::ringer_addr_t  addr_i,
  input  wire ringer_pkg::ringer_byte_t  wr_data_i,
  input  wire logic                      wr_en_i,
  input  wire logic                      rd_en_i,
  output ringer_pkg::ringer_byte_t       rd_data_o,
  output logic                           tone1_pwm_o,
  output logic                           tone2_pwm_o,
  output logic                           tone_mix_pwm_o,
  output logic                           tone1_period_o,
  output logic                           tone2_period_o
);
  import ringer_pkg::*;

  localparam int NCH = `RINGER_CHANNELS;

  // ************************************************************
  // Reset release
  // ************************************************************

  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_pipe <= 2'b00;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ************************************************************
  // Register storage
  // ************************************************************

  logic         clock_on;
  logic [1:0]   tone_on;
  ringer_vol_t  volume [NCH];
  ringer_byte_t first_channel_divider;
  ringer_byte_t second_channel_divider;
  ringer_byte_t divider [NCH];

  logic [1:0]   active;
  logic [1:0]   pwm_q;
  logic [1:0]   period_q;
  logic [1:0]   next_pwm;
  logic [1:0]   period_end;
  ringer_slot_t slot [NCH];

  logic         wr_gate;
  logic         wr_div1;
  logic         wr_div2;

  assign wr_gate = wr_en_i && (addr_i == `RINGER_CLK_GATE_ADDR);
  assign wr_div1 = wr_en_i && (addr_i == `RINGER_CH1_DIV_ADDR);
  assign wr_div2 = wr_en_i && (addr_i == `RINGER_CH2_DIV_ADDR);

  // Only bit 7 is kept; the reserved bits are dropped
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_on <= 1'b0;
    end
    else if (wr_gate)
    begin
      clock_on <= wr_data_i[`RINGER_CLK_ON_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_channel_divider <= `RINGER_REG_RESET;
    end
    else if (wr_div1)
    begin
      first_channel_divider <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      second_channel_divider <= `RINGER_REG_RESET;
    end
    else if (wr_div2)
    begin
      second_channel_divider <= wr_data_i;
    end
  end

  assign divider[0] = first_channel_divider;
  assign divider[1] = second_channel_divider;

  // ************************************************************
  // Tone tick and PWM carrier
  // ************************************************************

  logic       tick;
  logic [4:0] carrier;

  // The whole generator advances only while the clock gate is on
  ringer_slot_tick u_tick (
    .core_clk_i (core_clk_i),
    .rst_n      (rst_n),
    .run_i      (clock_on),
    .tick_o     (tick)
  );

  // Fine PWM step counter; compared against the volume level
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier <= 5'h00;
    end
    else if (clock_on)
    begin
      carrier <= carrier + 5'h01;
    end
  end

  // ************************************************************
  // Tone channels
  // ************************************************************

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    localparam ringer_addr_t CTRL_ADDR =
      9'(`RINGER_CH1_CTRL_ADDR + g * `RINGER_CH_ADDR_STEP);

    logic         wr_ctrl;
    tone_state_e  state;
    ringer_vol_t  vol_sh;
    ringer_byte_t div_sh;
    logic         running;

    assign wr_ctrl = wr_en_i && (addr_i == CTRL_ADDR);
    assign running = (state == TONE_RUN);
    assign active[g] = running;

    // Volume always takes the write
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        volume[g] <= 5'h00;
      end
      else if (wr_ctrl)
      begin
        volume[g] <= wr_data_i[`RINGER_VOL_MSB:0];
      end
    end

    // Enable ignores writes while the generator clock is stopped
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tone_on[g] <= 1'b0;
      end
      else if (wr_ctrl && clock_on)
      begin
        tone_on[g] <= wr_data_i[`RINGER_TONE_ON_BIT];
      end
    end

    // Settings are taken at the start and at each period boundary,
    // so a running tone shows a partial period only when its enable is cleared mid-period
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        state  <= TONE_IDLE;
        vol_sh <= 5'h00;
        div_sh <= 8'h00;
      end
      else if (clock_on)
      begin
        case (state)
          TONE_IDLE:
          begin
            if (tone_on[g])
            begin
              state  <= TONE_RUN;
              vol_sh <= volume[g];
              div_sh <= divider[g];
            end
          end
          TONE_RUN:
          begin
            if (!tone_on[g])
            begin
              state <= TONE_IDLE;
            end
            else if (period_end[g])
            begin
              vol_sh <= volume[g];
              div_sh <= divider[g];
            end
          end
          default:
          begin
            state <= TONE_IDLE;
          end
        endcase
      end
    end

    // Each slot lasts N+1 ticks, a period is 32 slots
    ringer_period_counter u_period (
      .core_clk_i   (core_clk_i),
      .rst_n        (rst_n),
      .clear_i      (!running),
      .step_i       (clock_on && tick && running),
      .limit_i      (div_sh),
      .slot_o       (slot[g]),
      .period_end_o (period_end[g])
    );

    // First half of the period (slots 0 to 15) carries PWM at duty volume/32
    assign next_pwm[g] = clock_on &&
                         running &&
                         (vol_sh != 5'h00) &&
                         !slot[g][4] &&
                         (carrier < vol_sh);

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pwm_q[g] <= 1'b0;
      end
      else
      begin
        pwm_q[g] <= next_pwm[g];
      end
    end

    // Period pulse lets software time a zero-volume period
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        period_q[g] <= 1'b0;
      end
      else
      begin
        period_q[g] <= period_end[g];
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  logic mix_q;

  // Both channels combine into the speaker drive
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mix_q <= 1'b0;
    end
    else
    begin
      mix_q <= |next_pwm;
    end
  end

  assign tone1_pwm_o    = pwm_q[0];
  assign tone2_pwm_o    = pwm_q[1];
  assign tone_mix_pwm_o = mix_q;
  assign tone1_period_o = period_q[0];
  assign tone2_period_o = period_q[1];

  // ************************************************************
  // Register read
  // ************************************************************

  ringer_byte_t next_rd_data;

  // Reserved bits and unmapped addresses read as zero
  always_comb
  begin
    next_rd_data = 8'h00;
    if (rd_en_i)
    begin
      case (addr_i)
        `RINGER_CLK_GATE_ADDR:
        begin
          next_rd_data[`RINGER_CLK_ON_BIT] = clock_on;
        end
        `RINGER_STATUS_ADDR:
        begin
          next_rd_data[`RINGER_CLK_ON_BIT] = clock_on;
          next_rd_data[`RINGER_STAT_PWM_LSB +: 2] = pwm_q;
          next_rd_data[1:0] = active;
        end
        `RINGER_CH1_CTRL_ADDR:
        begin
          next_rd_data[`RINGER_TONE_ON_BIT] = tone_on[0];
          next_rd_data[`RINGER_VOL_MSB:0] = volume[0];
        end
        `RINGER_CH1_DIV_ADDR:
        begin
          next_rd_data = first_channel_divider;
        end
        `RINGER_CH2_CTRL_ADDR:
        begin
          next_rd_data[`RINGER_TONE_ON_BIT] = tone_on[1];
          next_rd_data[`RINGER_VOL_MSB:0] = volume[1];
        end
        `RINGER_CH2_DIV_ADDR:
        begin
          next_rd_data = second_channel_divider;
        end
        `RINGER_CH1_POS_ADDR:
        begin
          next_rd_data[4:0] = slot[0];
        end
        `RINGER_CH2_POS_ADDR:
        begin
          next_rd_data[4:0] = slot[1];
        end
        default:
        begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule : dual_ringer_tone_pwm

// ==== include/ringer_defs.svh ====
// Offsets, field positions, reset values and timing figures of the ringer
`ifndef RINGER_DEFS_SVH
`define RINGER_DEFS_SVH

`define RINGER_ADDR_W          9
`define RINGER_DATA_W          8
`define RINGER_CLK_GATE_ADDR   9'h1a0
`define RINGER_STATUS_ADDR     9'h1a1
`define RINGER_CH1_CTRL_ADDR   9'h1a2
`define RINGER_CH1_DIV_ADDR    9'h1a3
`define RINGER_CH2_CTRL_ADDR   9'h1a4
`define RINGER_CH2_DIV_ADDR    9'h1a5
`define RINGER_CH1_POS_ADDR    9'h1a6
`define RINGER_CH2_POS_ADDR    9'h1a7
`define RINGER_CH_ADDR_STEP    9'h002
`define RINGER_REG_RESET       8'h00
`define RINGER_CLK_ON_BIT      7
`define RINGER_TONE_ON_BIT     7
`define RINGER_VOL_MSB         4
`define RINGER_STAT_PWM_LSB    2
`define RINGER_CHANNELS        2
`define RINGER_SLOT_LAST       5'h1f

// Tone base clock and its fixed prescaler, in kHz
`define RINGER_BASE_KHZ        12288
`define RINGER_BASE_PRESCALE   16
`define RINGER_TICK_KHZ        (`RINGER_BASE_KHZ / `RINGER_BASE_PRESCALE)
// Core clock period in ns and the rate derived from it, in kHz
`define RINGER_CORE_PERIOD_NS  50
`define RINGER_CORE_KHZ        (1000000 / `RINGER_CORE_PERIOD_NS)
`define RINGER_ACC_W           15

`endif

// ==== include/ringer_pkg.sv ====
// Types shared by the ringer tone generator files
package ringer_pkg;

  typedef logic [8:0] ringer_addr_t;
  typedef logic [7:0] ringer_byte_t;
  typedef logic [4:0] ringer_vol_t;
  typedef logic [4:0] ringer_slot_t;

  typedef enum logic [0:0] {
    TONE_IDLE,
    TONE_RUN
  } tone_state_e;

endpackage : ringer_pkg

// ==== design/ringer_slot_tick.sv ====
// Fractional divider making the 768 kHz tone tick from the core clock
`include "ringer_defs.svh"

module ringer_slot_tick (
  input  wire logic core_clk_i,
  input  wire logic rst_n,
  input  wire logic run_i,
  output logic      tick_o
);
  import ringer_pkg::*;

  localparam logic [15:0] TICK_INC = 16'(`RINGER_TICK_KHZ);
  localparam logic [15:0] MODULUS  = 16'(`RINGER_CORE_KHZ);

  logic [`RINGER_ACC_W-1:0] acc;
  logic [15:0]              sum;

  assign sum = {1'b0, acc} + TICK_INC;

  // Average tick rate is exactly TICK_INC / MODULUS of the core rate
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc    <= '0;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      tick_o <= 1'b0;
    end
    else if (sum >= MODULUS)
    begin
      acc    <= 15'(sum - MODULUS);
      tick_o <= 1'b1;
    end
    else
    begin
      acc    <= 15'(sum);
      tick_o <= 1'b0;
    end
  end

endmodule : ringer_slot_tick

// ==== design/ringer_period_counter.sv ====
// Counts ticks into the 32 sub-slots of one tone period
`include "ringer_defs.svh"

module ringer_period_counter (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n,
  input  wire logic                      clear_i,
  input  wire logic                      step_i,
  input  wire logic [7:0]                limit_i,
  output ringer_pkg::ringer_slot_t       slot_o,
  output logic                           period_end_o
);
  import ringer_pkg::*;

  logic [7:0] tick_cnt;
  logic       slot_done;

  assign slot_done    = step_i && (tick_cnt == limit_i);
  assign period_end_o = slot_done && (slot_o == `RINGER_SLOT_LAST);

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 8'h00;
      slot_o   <= 5'h00;
    end
    else if (clear_i)
    begin
      tick_cnt <= 8'h00;
      slot_o   <= 5'h00;
    end
    else if (slot_done)
    begin
      tick_cnt <= 8'h00;
      slot_o   <= slot_o + 5'h01;
    end
    else if (step_i)
    begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

endmodule : ringer_period_counter

// ==== tb/speaker_mix_model.sv ====
// Speaker path model timing each tone period and its PWM high time
module speaker_mix_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] pwm_i,
  input  wire logic [1:0] period_i,
  output logic [15:0]     len_o [2],
  output logic [15:0]     high_o [2]
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] cnt [2];
  logic [15:0] hc [2];

  // Both tones reach the speaker; each is timed on its own
  always_ff @(posedge clk_i)
    for (int i = 0; i < 2; i++)
      if (!rst_n_i || period_i[i])
      begin
        len_o[i]  <= rst_n_i ? cnt[i] : 16'h0000;
        high_o[i] <= rst_n_i ? hc[i] : 16'h0000;
        cnt[i]    <= 16'h0001;
        hc[i]     <= {15'h0000, pwm_i[i] & rst_n_i};
      end
      else
      begin
        cnt[i] <= cnt[i] + 16'h0001;
        hc[i]  <= hc[i] + {15'h0000, pwm_i[i]};
      end
endmodule : speaker_mix_model

// ==== tb/dual_ringer_tone_pwm_monitor.sv ====
// Port-level checks for the ringer tone generator
`include "ringer_defs.svh"

module dual_ringer_tone_pwm_monitor (
  input wire logic                     core_clk_i,
  input wire logic                     arst_n_i,
  input wire ringer_pkg::ringer_addr_t addr_i,
  input wire ringer_pkg::ringer_byte_t wr_data_i,
  input wire logic                     wr_en_i,
  input wire logic                     rd_en_i,
  input wire ringer_pkg::ringer_byte_t rd_data_o,
  input wire logic                     tone1_pwm_o,
  input wire logic                     tone2_pwm_o,
  input wire logic                     tone_mix_pwm_o,
  input wire logic                     tone1_period_o,
  input wire logic                     tone2_period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ringer_pkg::*;

  logic        gate;
  logic        on1;
  ringer_vol_t vol1;
  ringer_vol_t vol1_q;
  logic        mute1;
  logic        wr1;

  assign wr1 = wr_en_i && addr_i == `RINGER_CH1_CTRL_ADDR;

  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ****************************************
  // Shadow of the written settings
  // ****************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      gate <= 1'b0;
    else if (wr_en_i && addr_i == `RINGER_CLK_GATE_ADDR)
      gate <= wr_data_i[7];

  // Volume before the last edge; settings are taken at the period end,
  // on the same edge that raises the period pulse
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      vol1_q <= 5'h00;
    else
      vol1_q <= vol1;

  // Mute flag: a period ended while the volume was zero
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      on1   <= 1'b0;
      vol1  <= 5'h00;
      mute1 <= 1'b0;
    end
    else if (wr1)
    begin
      if (gate)
        on1 <= wr_data_i[7];
      vol1  <= wr_data_i[4:0];
      mute1 <= 1'b0;
    end
    else if (tone1_period_o && vol1_q == 5'h00)
      mute1 <= 1'b1;

  // ****************************************
  // Assertions
  // ****************************************
  mix_is_or_a: assert property (
    tone_mix_pwm_o == (tone1_pwm_o | tone2_pwm_o))
    else $error("mix output differs from OR of channels");
  read_idle_a: assert property (!rd_en_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside read");
  gate_read_a: assert property (
    rd_en_i && addr_i == `RINGER_CLK_GATE_ADDR
    |=> rd_data_o == {$past(gate), 7'h00})
    else $error("clock gate readback wrong");
  ctrl_read_a: assert property (
    rd_en_i && addr_i == `RINGER_CH1_CTRL_ADDR
    |=> rd_data_o == {$past(on1), 2'b00, $past(vol1)})
    else $error("channel one control readback wrong");
  ctrl_reserved_a: assert property (
    rd_en_i && addr_i == `RINGER_CH2_CTRL_ADDR |=> rd_data_o[6:5] == 2'b00)
    else $error("channel two reserved bits not zero");
  unmapped_read_a: assert property (
    rd_en_i && (addr_i < 9'h1a0 || addr_i > 9'h1a7) |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  gate_off_a: assert property (
    !gate [*2] |-> !tone1_pwm_o && !tone2_pwm_o && !tone1_period_o
    && !tone2_period_o)
    else $error("tone activity with clock gated off");
  zero_volume_a: assert property (mute1 |-> ##2 !tone1_pwm_o)
    else $error("channel one not muted at zero volume");
  pulse_one_a: assert property (
    tone1_period_o |=> !tone1_period_o [*8])
    else $error("channel one period pulse too long");
  pulse_two_a: assert property (
    tone2_period_o |=> !tone2_period_o [*8])
    else $error("channel two period pulse too long");
endmodule : dual_ringer_tone_pwm_monitor

bind dual_ringer_tone_pwm dual_ringer_tone_pwm_monitor u_monitor (
  .core_clk_i, .arst_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
  .rd_data_o, .tone1_pwm_o, .tone2_pwm_o, .tone_mix_pwm_o,
  .tone1_period_o, .tone2_period_o
);

// ==== tb/tb_top.sv ====
// Self-checking bench for the two-channel ringer tone generator
`include "ringer_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ringer_pkg::*;

  logic         core_clk_i = 1'b0;
  logic         arst_n_i = 1'b0;
  ringer_addr_t addr_i = 9'h000;
  ringer_byte_t wr_data_i = 8'h00;
  logic         wr_en_i = 1'b0;
  logic         rd_en_i = 1'b0;
  ringer_byte_t rd_data_o;
  logic         tone1_pwm_o;
  logic         tone2_pwm_o;
  logic         tone_mix_pwm_o;
  logic         tone1_period_o;
  logic         tone2_period_o;
  logic [1:0]   per;
  logic [15:0]  len_o [2];
  logic [15:0]  high_o [2];
  int           num_errors = 0;
  int           comparisons = 0;

  assign per = {tone2_period_o, tone1_period_o};

  always #25 core_clk_i = ~core_clk_i;

  dual_ringer_tone_pwm u_dut (
    .core_clk_i, .arst_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
    .rd_data_o, .tone1_pwm_o, .tone2_pwm_o, .tone_mix_pwm_o,
    .tone1_period_o, .tone2_period_o
  );

  speaker_mix_model u_mix (
    .clk_i    (core_clk_i),
    .rst_n_i  (arst_n_i),
    .pwm_i    ({tone2_pwm_o, tone1_pwm_o}),
    .period_i (per),
    .len_o    (len_o),
    .high_o   (high_o)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(string what, logic [15:0] got, int lo, int hi);
    comparisons++;
    if (($signed({1'b0, got}) >= lo && $signed({1'b0, got}) <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk

  task automatic wr(ringer_addr_t a, ringer_byte_t d);
    @(posedge core_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i   <= 1'b0;
  endtask : wr

  task automatic rd(ringer_addr_t a, ringer_byte_t exp, string what);
    @(posedge core_clk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk(what, rd_data_o, exp, exp);
  endtask : rd

  task automatic wait_per(int ch);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk_i);
      n++;
    end
    while (per[ch] !== 1'b1 && n < 6000);
    if (n >= 6000)
    begin
      num_errors++;
      $display("Error period pulse expected %0d seen %0d", 1, per[ch]);
      wrap_up();
    end
  endtask : wait_per

  // Times one whole period; the first pulse may close a partial one
  task automatic meas(int ch, int n, int vol);
    int len;
    int hi;
    int tol;
    len = (n + 1) * 32 * `RINGER_CORE_KHZ / `RINGER_TICK_KHZ;
    hi  = len * vol / 64;
    tol = (vol > 0) ? 8 : 0;
    wait_per(ch);
    wait_per(ch);
    @(negedge core_clk_i);
    chk("period cycles", len_o[ch], len - 2, len + 2);
    chk("pwm high cycles", high_o[ch], hi - tol, hi + tol);
  endtask : meas

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (ringer_addr_t a = 9'h1a0; a <= 9'h1a8; a++)
      rd(a, 8'h00, "reset value");
    rd(9'h000, 8'h00, "unmapped read");
  endtask : t_reset

  task automatic t_gated();
    wr(`RINGER_CH1_CTRL_ADDR, 8'hff);
    rd(`RINGER_CH1_CTRL_ADDR, 8'h1f, "ctrl gated");
    wr(`RINGER_CLK_GATE_ADDR, 8'hff);
    rd(`RINGER_CLK_GATE_ADDR, 8'h80, "clock gate");
    wr(`RINGER_CH1_CTRL_ADDR, 8'hff);
    rd(`RINGER_CH1_CTRL_ADDR, 8'h9f, "ctrl running");
    wr(9'h1a8, 8'h55);
    rd(9'h1a8, 8'h00, "unmapped write");
    wr(`RINGER_CH1_DIV_ADDR, 8'ha5);
    rd(`RINGER_CH1_DIV_ADDR, 8'ha5, "divider one");
    wr(`RINGER_CH1_CTRL_ADDR, 8'h00);
  endtask : t_gated

  task automatic t_tones();
    wr(`RINGER_CH1_DIV_ADDR, 8'h00);
    wr(`RINGER_CH2_DIV_ADDR, 8'h02);
    rd(`RINGER_CH2_DIV_ADDR, 8'h02, "divider two");
    wr(`RINGER_CH1_CTRL_ADDR, 8'h9f);
    wr(`RINGER_CH2_CTRL_ADDR, 8'h90);
    meas(0, 0, 31);
    meas(1, 2, 16);
  endtask : t_tones

  task automatic t_mute();
    wr(`RINGER_CH1_CTRL_ADDR, 8'h80);
    meas(0, 0, 0);
  endtask : t_mute

  task automatic t_stop();
    wr(`RINGER_CH1_CTRL_ADDR, 8'h00);
    wr(`RINGER_CH2_CTRL_ADDR, 8'h80);
    wait_per(1);
    wait_per(1);
    rd(`RINGER_STATUS_ADDR, 8'h82, "status running");
    wr(`RINGER_CH2_CTRL_ADDR, 8'h00);
    wr(`RINGER_CLK_GATE_ADDR, 8'h00);
    wr(`RINGER_CH2_CTRL_ADDR, 8'h90);
    rd(`RINGER_CH2_CTRL_ADDR, 8'h10, "enable gated");
    repeat (3) @(negedge core_clk_i);
    chk("pwm gated",
        {tone_mix_pwm_o, tone2_pwm_o, tone1_pwm_o}, 0, 0);
  endtask : t_stop

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset();
    t_gated();
    t_tones();
    t_mute();
    t_stop();
    wrap_up();
  end
endmodule : tb_top
